// [core/twbtd_core.sv]
// Bit-timing core of a two-wire controller: START, bit, STOP, repeated
// START and transmitting-slave clock hold, all timed in core clock cycles.
// Assumes open-drain pads outside and a sequencer issuing commands.
// Summary of operation
// - Every interval is a whole count of core clock cycles.
// - SCL and SDA are seen about rate*2+1 cycles after the pins.
// - Intervals measured on the bus start from the filtered levels.
// - The filter samples once every rate core clock cycles.
// - SCL low and SCL high each last half the divider value.
// - Select codes map to divider values in the listed pairwise order.
// - START hold is divider/16 halved until below 16, or until below 9 if bit 5 set.
// - Data hold is 8 plus 16<<sel[4:2] times a factor from sel bits 5,1.
// - Master data setup is half the divider minus the data hold.
// - Repeated START setup is the divider plus the START hold.
// - STOP follows filtered SCL high by at least 4 cycles.
// - SCL and SDA are only pulled low or released.
// - Each divider value gives its own SCL output rate.
// - As transmitting slave, SCL is pulled low hold+8 after SCL falls.
module twbtd_core (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [5:0] divider_select_in,
  input wire logic [5:0] filter_sample_rate_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_in,
  input wire logic cmd_bit_in,
  input wire logic slave_tx_in,
  input wire logic slave_release_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic rx_bit_out,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out
);
  localparam int W = twbtd_pkg::CNT_W;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_PARK = 4'h2,
    ST_HOLD = 4'h3,
    ST_SETUP = 4'h4,
    ST_HIGH_WAIT = 4'h5,
    ST_HIGH = 4'h6,
    ST_STOP = 4'h7,
    ST_RS_SETUP = 4'h8,
    ST_SLV_WAIT = 4'h9,
    ST_SLV_HOLD = 4'hA
  } twbtd_state_e;

  twbtd_state_e state;
  twbtd_state_e next_state;
  twbtd_pkg::twbtd_cmd_e op;
  twbtd_pkg::twbtd_cmd_e next_op;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic [5:0] sel;
  logic [5:0] next_sel;
  logic [5:0] rate;
  logic [5:0] next_rate;
  logic tx_bit;
  logic next_tx_bit;
  logic scl_low;
  logic next_scl_low;
  logic sda_low;
  logic next_sda_low;
  logic done;
  logic next_done;
  logic rx_bit;
  logic next_rx_bit;
  logic scl_seen;
  logic [W-1:0] d_val;
  logic [W-1:0] half;
  logic [W-1:0] t_start;
  logic [W-1:0] t_hold;
  logic [W-1:0] t_setup;
  logic last;
  logic scl_fell;
  logic [5:0] sel_eff;

  twbtd_filt_if fi();

  assign fi.scl_raw = scl_in;
  assign fi.sda_raw = sda_in;
  assign fi.rate = rate;

  twbtd_filter u_filter (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .f(fi.filt)
  );

  always_comb begin
    // The first count of a command must use the settings taken with it
    sel_eff = (state == ST_IDLE || state == ST_PARK) ?
      divider_select_in : sel;
    d_val = twbtd_pkg::twbtd_div(sel_eff);
    half = d_val >> 1;
    t_start = twbtd_pkg::twbtd_start_hold(sel_eff, d_val);
    t_hold = twbtd_pkg::twbtd_data_hold(sel_eff);
    // A hold longer than the half period still leaves one setup cycle
    t_setup = (half > t_hold) ? half - t_hold : W'(1);
    last = (cnt <= W'(1));
    scl_fell = scl_seen && !fi.scl_q;
  end

  // Fixed-level drivers: a pin is either pulled low or let go
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_low;
  assign sda_oe_out = sda_low;
  assign done_out = done;
  assign rx_bit_out = rx_bit;
  assign cmd_ready_out = (state == ST_IDLE) || (state == ST_PARK);

  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = last ? cnt : cnt - 1'b1;
    next_sel = sel;
    next_rate = rate;
    next_tx_bit = tx_bit;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_done = 1'b0;
    next_rx_bit = rx_bit;
    case (state)
      ST_IDLE: begin
        next_sel = divider_select_in;
        next_rate = filter_sample_rate_in;
        if (cmd_valid_in && cmd_in == twbtd_pkg::TWBTD_CMD_START) begin
          next_sda_low = 1'b1;
          next_cnt = t_start;
          next_state = ST_START;
        end else if (slave_tx_in && scl_fell) begin
          next_cnt = t_hold + W'(twbtd_pkg::SLV_EXTRA);
          next_state = ST_SLV_WAIT;
        end
      end
      ST_START: begin
        if (last) begin
          next_scl_low = 1'b1;
          next_done = 1'b1;
          next_state = ST_PARK;
        end
      end
      ST_PARK: begin
        next_sel = divider_select_in;
        next_rate = filter_sample_rate_in;
        if (cmd_valid_in && cmd_in != twbtd_pkg::TWBTD_CMD_START) begin
          next_op = twbtd_pkg::twbtd_cmd_e'(cmd_in);
          case (cmd_in)
            twbtd_pkg::TWBTD_CMD_BIT: next_tx_bit = cmd_bit_in;
            twbtd_pkg::TWBTD_CMD_STOP: next_tx_bit = 1'b0;
            default: next_tx_bit = 1'b1;
          endcase
          next_cnt = t_hold;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (last) begin
          next_sda_low = !tx_bit;
          next_cnt = t_setup;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (last) begin
          next_scl_low = 1'b0;
          next_state = ST_HIGH_WAIT;
        end
      end
      ST_HIGH_WAIT: begin
        // Slaves may stretch; high time counts from the qualified edge
        if (fi.scl_q) begin
          case (op)
            twbtd_pkg::TWBTD_CMD_STOP: begin
              next_cnt = W'(twbtd_pkg::STOP_SETUP_CYC);
              next_state = ST_STOP;
            end
            twbtd_pkg::TWBTD_CMD_RSTART: begin
              next_cnt = d_val + t_start;
              next_state = ST_RS_SETUP;
            end
            default: begin
              next_cnt = half;
              next_state = ST_HIGH;
            end
          endcase
        end
      end
      ST_HIGH: begin
        if (last) begin
          next_rx_bit = fi.sda_q;
          next_scl_low = 1'b1;
          next_done = 1'b1;
          next_state = ST_PARK;
        end
      end
      ST_STOP: begin
        if (last) begin
          next_sda_low = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_RS_SETUP: begin
        if (last) begin
          next_sda_low = 1'b1;
          next_cnt = t_start;
          next_state = ST_START;
        end
      end
      ST_SLV_WAIT: begin
        if (last) begin
          next_scl_low = 1'b1;
          next_state = ST_SLV_HOLD;
        end
      end
      ST_SLV_HOLD: begin
        if (slave_release_in) begin
          next_scl_low = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      op <= twbtd_pkg::TWBTD_CMD_START;
      cnt <= '0;
      sel <= '0;
      rate <= '0;
      tx_bit <= 1'b1;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      done <= 1'b0;
      rx_bit <= 1'b0;
      scl_seen <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      sel <= next_sel;
      rate <= next_rate;
      tx_bit <= next_tx_bit;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      done <= next_done;
      rx_bit <= next_rx_bit;
      scl_seen <= fi.scl_q;
    end
  end
endmodule

// [core/twbtd_pkg.sv]
// Shared constants, command codes and timing functions of the bit-timing core.
// Assumes all counts are in core clock cycles; nothing here holds state.
package twbtd_pkg;
  localparam int SEL_W = 6;
  localparam int RATE_W = 6;
  localparam int CNT_W = 18;
  localparam int CLK_MHZ = 200;
  // Divider table bases for the low half of the select codes
  localparam int DIV_EVEN_LO = 288;
  localparam int DIV_EVEN_HI = 320;
  localparam int DIV_ODD_LO = 384;
  localparam int DIV_ODD_HI = 448;
  localparam int DIV_LAST = 61440;
  // Divider table of the upper select codes
  localparam int DIV_20 = 160;
  localparam int DIV_21 = 192;
  localparam int DIV_22 = 224;
  localparam int DIV_23 = 256;
  localparam int DIV_24 = 320;
  localparam int DIV_25 = 384;
  localparam int DIV_GRP_0 = 480;
  localparam int DIV_GRP_1 = 512;
  localparam int DIV_GRP_2 = 640;
  localparam int DIV_GRP_3 = 768;
  localparam logic [5:0] SEL_HIGH_FIRST = 6'h20;
  localparam logic [5:0] SEL_GROUP_FIRST = 6'h26;
  localparam logic [5:0] SEL_LAST = 6'h1F;
  // Start hold, data hold and fixed intervals
  localparam int START_PRESCALE = 4;
  localparam int START_LIM_N = 16;
  localparam int START_LIM_M = 9;
  localparam int HOLD_BASE = 8;
  localparam int HOLD_UNIT = 16;
  localparam int HOLD_FACTOR = 5;
  localparam int SLV_EXTRA = 8;
  localparam int STOP_SETUP_CYC = 4;
  localparam logic [1:0] BUS_IDLE = 2'h3;

  typedef enum logic [1:0] {
    TWBTD_CMD_START = 2'b00,
    TWBTD_CMD_BIT = 2'b01,
    TWBTD_CMD_STOP = 2'b10,
    TWBTD_CMD_RSTART = 2'b11
  } twbtd_cmd_e;

  function automatic logic [CNT_W-1:0] twbtd_div(input logic [5:0] s);
    logic [CNT_W-1:0] b;
    logic [5:0] o;
    b = '0;
    o = '0;
    if (!s[5]) begin
      case (s[1:0])
        2'b00: b = CNT_W'(DIV_EVEN_LO);
        2'b01: b = CNT_W'(DIV_EVEN_HI);
        2'b10: b = CNT_W'(DIV_ODD_LO);
        default: b = CNT_W'(DIV_ODD_HI);
      endcase
      b = b << s[4:2];
      if (s == SEL_LAST) begin
        b = CNT_W'(DIV_LAST);
      end
    end else if (s < SEL_GROUP_FIRST) begin
      case (s[2:0])
        3'h0: b = CNT_W'(DIV_20);
        3'h1: b = CNT_W'(DIV_21);
        3'h2: b = CNT_W'(DIV_22);
        3'h3: b = CNT_W'(DIV_23);
        3'h4: b = CNT_W'(DIV_24);
        default: b = CNT_W'(DIV_25);
      endcase
    end else begin
      o = s - SEL_GROUP_FIRST;
      case (o[1:0])
        2'b00: b = CNT_W'(DIV_GRP_0);
        2'b01: b = CNT_W'(DIV_GRP_1);
        2'b10: b = CNT_W'(DIV_GRP_2);
        default: b = CNT_W'(DIV_GRP_3);
      endcase
      b = b << o[5:2];
    end
    return b;
  endfunction

  function automatic logic [CNT_W-1:0] twbtd_start_hold(
      input logic [5:0] s, input logic [CNT_W-1:0] d);
    logic [CNT_W-1:0] v;
    logic [CNT_W-1:0] lim;
    v = d >> START_PRESCALE;
    lim = s[5] ? CNT_W'(START_LIM_M) : CNT_W'(START_LIM_N);
    for (int i = 0; i < CNT_W; i++) begin
      if (v >= lim) begin
        v = v >> 1;
      end
    end
    if (v == '0) begin
      v = CNT_W'(1);
    end
    return v;
  endfunction

  function automatic logic [CNT_W-1:0] twbtd_data_hold(input logic [5:0] s);
    logic [CNT_W-1:0] f;
    case ({s[5], s[1]})
      2'b10: f = CNT_W'(HOLD_FACTOR - 4);
      2'b11: f = CNT_W'(HOLD_FACTOR - 3);
      2'b00: f = CNT_W'(HOLD_FACTOR - 2);
      default: f = CNT_W'(HOLD_FACTOR - 1);
    endcase
    return CNT_W'(HOLD_BASE) + ((CNT_W'(HOLD_UNIT) << s[4:2]) * f);
  endfunction
endpackage

// [core/twbtd_filt_if.sv]
// Carrier between the core and its input qualification filter.
// Assumes raw bus levels are already at the logic level of the pins.
interface twbtd_filt_if;
  logic scl_raw;
  logic sda_raw;
  logic [twbtd_pkg::RATE_W-1:0] rate;
  logic scl_q;
  logic sda_q;
  modport filt (input scl_raw, input sda_raw, input rate,
    output scl_q, output sda_q);
  modport core (output scl_raw, output sda_raw, output rate,
    input scl_q, input sda_q);
endinterface

// [core/twbtd_filter.sv]
// Input qualification filter for SCL and SDA.
// Assumes raw levels are asynchronous to the core clock.
module twbtd_filter (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  twbtd_filt_if.filt f
);
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] samp;
  logic [1:0] qual;
  logic [twbtd_pkg::RATE_W-1:0] div;
  logic [1:0] next_samp;
  logic [1:0] next_qual;
  logic [twbtd_pkg::RATE_W-1:0] next_div;
  logic tick;

  assign f.scl_q = qual[1];
  assign f.sda_q = qual[0];

  always_comb begin
    // Sample clock every rate cycles; a zero rate acts as one
    tick = (div + 1'b1 >= f.rate);
    next_div = tick ? '0 : div + 1'b1;
    next_samp = tick ? sync2 : samp;
    // Two agreeing samples qualify a level: about 2*rate+1 cycles late
    next_qual = (tick && sync2 == samp) ? sync2 : qual;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1 <= twbtd_pkg::BUS_IDLE;
      sync2 <= twbtd_pkg::BUS_IDLE;
      samp <= twbtd_pkg::BUS_IDLE;
      qual <= twbtd_pkg::BUS_IDLE;
      div <= '0;
    end else begin
      sync1 <= {f.scl_raw, f.sda_raw};
      sync2 <= sync1;
      samp <= next_samp;
      qual <= next_qual;
      div <= next_div;
    end
  end
endmodule

// [tb/twbtd_monitor.sv]
// Port checker of the bit-timing core.
// Assumes pulled-up wires fed back on scl_in and sda_in, bus idle at reset.
module twbtd_monitor (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_in,
  input wire logic scl_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic rx_bit_out,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Saturating run lengths of the SCL wire; high at reset as the bus idles
  logic [7:0] hi_cnt, lo_cnt, next_hi_cnt, next_lo_cnt;
  always_comb begin
    next_hi_cnt = !scl_in ? 8'h00 :
      (hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01;
    next_lo_cnt = scl_in ? 8'h00 :
      (lo_cnt == 8'hFF) ? lo_cnt : lo_cnt + 8'h01;
  end
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hi_cnt <= 8'hFF;
      lo_cnt <= 8'h00;
    end else begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end
  AST_NEVER_HIGH: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  AST_START_ORDER: assert property (cmd_valid_in && cmd_ready_out &&
    cmd_in == twbtd_pkg::TWBTD_CMD_START && !scl_oe_out && !sda_oe_out
    |=> (sda_oe_out && !scl_oe_out) [*4])
    else $error("start hold too short");
  AST_DONE_PULSE: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  AST_DONE_READY: assert property (done_out |-> cmd_ready_out)
    else $error("done while busy");
  AST_STOP_SETUP: assert property ($fell(sda_oe_out) && !scl_oe_out
    |-> hi_cnt >= 8'h05)
    else $error("stop too soon after scl high");
  AST_HIGH_MIN: assert property ($rose(scl_oe_out) && !sda_oe_out &&
    hi_cnt != 8'h00 |-> hi_cnt >= 8'h50)
    else $error("scl high period too short");
  AST_SLAVE_WAIT: assert property ($rose(scl_oe_out) && hi_cnt == 8'h00
    |-> lo_cnt >= 8'h20)
    else $error("slave clock hold too early");
  AST_RX_AT_END: assert property ($changed(rx_bit_out)
    |-> done_out || $past(done_out))
    else $error("received bit moved outside bit end");
  COV_START: cover property ($rose(sda_oe_out) && !scl_oe_out);
  COV_STOP: cover property ($fell(sda_oe_out) && !scl_oe_out);
  COV_SLAVE: cover property ($rose(scl_oe_out) && hi_cnt == 8'h00);
endmodule

bind twbtd_core twbtd_monitor twbtd_monitor_inst (.core_clk_in, .sys_rst_in,
  .cmd_valid_in, .cmd_in, .scl_in, .cmd_ready_out, .done_out, .rx_bit_out,
  .scl_out, .sda_out, .scl_oe_out, .sda_oe_out);

// [tb/twbtd_bus_model.sv]
// Far side of the bus: a slave that stretches SCL, and an outside master.
// Assumes the bench sets stretch length and the outside master's pull.
module twbtd_bus_model (
  input wire logic clk_in,
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  input wire logic [7:0] stretch_in,
  input wire logic ext_pull_in,
  output logic scl_out,
  output logic sda_out
);
  logic [7:0] hold_cnt;
  logic prev_oe;
  logic pull;
  initial begin
    hold_cnt = 8'h00;
    prev_oe = 1'b0;
  end
  always @(posedge clk_in) begin
    prev_oe <= scl_oe_in;
    if (prev_oe && !scl_oe_in)
      hold_cnt <= stretch_in;
    else if (hold_cnt != 8'h00)
      hold_cnt <= hold_cnt - 8'h01;
  end
  // Stretch starts the same cycle the core lets go, so no high glitch
  assign pull = hold_cnt != 8'h00 ||
    (prev_oe && !scl_oe_in && stretch_in != 8'h00);
  // Outside master pull is held long by the bench
  assign scl_out = !(scl_oe_in || pull || ext_pull_in);
  assign sda_out = !sda_oe_in;
endmodule

// [tb/twbtd_core_tb.sv]
// Self-checking bench of the bit-timing core.
// Assumes the bus model and the port checker are compiled alongside.
module twbtd_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, sys_rst_in, cmd_valid_in, cmd_bit_in, slave_tx_in;
  logic slave_rel, ext_pull, scl_w, sda_w, ready, done, rx, scl_oe, sda_oe;
  logic [5:0] sel, rate;
  logic [1:0] cmd;
  logic [7:0] stretch;
  int fail_count, n_tests, n, n_sda, n_rel, hi, hi_sl;
  twbtd_core twbtd_core_inst (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .divider_select_in(sel),
    .filter_sample_rate_in(rate), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd), .cmd_bit_in(cmd_bit_in), .slave_tx_in(slave_tx_in),
    .slave_release_in(slave_rel), .scl_in(scl_w), .sda_in(sda_w),
    .cmd_ready_out(ready), .done_out(done), .rx_bit_out(rx),
    .scl_out(), .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe));
  twbtd_bus_model twbtd_bus_model_inst (.clk_in(core_clk_in),
    .scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .stretch_in(stretch),
    .ext_pull_in(ext_pull), .scl_out(scl_w), .sda_out(sda_w));
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string nm, input int lo, input int up, input int g);
    n_tests++;
    if (g < lo || g > up) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, up, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Issue one command, then watch the bus until done, bounded
  task automatic run(input logic [1:0] c, input logic b, input int lim);
    logic s0;
    s0 = sda_oe;
    n = 0;
    n_sda = -1;
    n_rel = -1;
    hi = 0;
    hi_sl = 0;
    for (int k = 0; k < 50 && ready !== 1'b1; k++) @(posedge core_clk_in) #1;
    if (ready !== 1'b1) begin
      fail_count++;
      $display("[ERR] ready expected 1 seen %b", ready);
      finish_test();
    end
    cmd = c;
    cmd_bit_in = b;
    cmd_valid_in = 1'b1;
    @(posedge core_clk_in) #1;
    cmd_valid_in = 1'b0;
    while (done !== 1'b1 && n < lim) begin
      if (sda_oe !== s0 && n_sda < 0) n_sda = n;
      if (scl_oe === 1'b0 && n_rel < 0) n_rel = n;
      hi += scl_w;
      if (scl_w === 1'b1 && sda_oe === 1'b0) hi_sl++;
      @(posedge core_clk_in) #1;
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("[ERR] done expected within %0d seen none", lim);
      finish_test();
    end
  endtask
  task automatic t_start();
    logic [5:0] s[3] = '{6'h20, 6'h00, 6'h26};
    int t[3] = '{5, 9, 7};
    foreach (s[i]) begin
      sel = s[i];
      run(2'b00, 1'b0, 400);
      chk("start hold", t[i], t[i] + 2, n);
      chkb("start sda", 1'b1, sda_oe);
      run(2'b10, 1'b0, 2000);
      chkb("stop scl", 1'b0, scl_oe);
      chkb("stop sda", 1'b0, sda_oe);
    end
    $display("test start done");
  endtask
  task automatic t_bits(input logic [5:0] s, input logic [5:0] r,
      input int d, input int h, input int ts, input int rw);
    sel = s;
    rate = r;
    run(2'b00, 1'b0, 400);
    run(2'b01, 1'b1, 4000);
    chk("data hold", h, h + 2, n_sda);
    chk("scl low", d / 2, d / 2 + 2, n_rel);
    chk("scl high", d / 2 + 2 * rw + 1, d / 2 + 2 * rw + 6, hi);
    chkb("rx one", 1'b1, rx);
    stretch = 8'h28;
    run(2'b01, 1'b0, 4000);
    chk("stretched high", d / 2 + 2 * rw + 1, d / 2 + 2 * rw + 6, hi);
    chkb("rx zero", 1'b0, rx);
    stretch = 8'h00;
    run(2'b11, 1'b0, 8000);
    chk("rstart setup", d + ts, d + ts + 2 * rw + 6, hi_sl);
    chkb("rstart park", 1'b1, scl_oe && sda_oe);
    run(2'b10, 1'b0, 4000);
    chkb("stop idle", 1'b0, scl_oe || sda_oe);
    $display("test bits sel %h done", s);
  endtask
  task automatic t_refuse();
    cmd = 2'b01;
    cmd_valid_in = 1'b1;
    @(posedge core_clk_in) #1;
    cmd_valid_in = 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge core_clk_in) #1;
      n += (done === 1'b1);
    end
    chk("idle bit ignored", 0, 0, n);
    $display("test refuse done");
  endtask
  task automatic t_slave();
    sel = 6'h20;
    rate = 6'h01;
    slave_tx_in = 1'b1;
    repeat (2) @(posedge core_clk_in) #1;
    ext_pull = 1'b1;
    n = 0;
    while (scl_oe !== 1'b1 && n < 200) begin
      @(posedge core_clk_in) #1;
      n++;
    end
    chk("slave wait", 32, 40, n);
    ext_pull = 1'b0;
    slave_rel = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(posedge core_clk_in) #1;
      n++;
    end
    chk("slave release", 0, 49, n);
    chkb("slave scl free", 1'b0, scl_oe);
    slave_rel = 1'b0;
    slave_tx_in = 1'b0;
    $display("test slave done");
  endtask
  initial begin
    sys_rst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_bit_in = 1'b0;
    cmd = 2'b00;
    slave_tx_in = 1'b0;
    slave_rel = 1'b0;
    ext_pull = 1'b0;
    stretch = 8'h00;
    sel = 6'h20;
    rate = 6'h01;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(posedge core_clk_in);
    #1 sys_rst_in = 1'b0;
    t_start();
    t_bits(6'h20, 6'h01, 160, 24, 5, 1);
    t_bits(6'h00, 6'h03, 288, 56, 9, 3);
    t_bits(6'h23, 6'h00, 256, 40, 8, 1);
    t_bits(6'h02, 6'h02, 384, 72, 12, 2);
    t_refuse();
    t_slave();
    finish_test();
  end
endmodule
